// [rtl/cmps_consts.vh]
`ifndef CMPS_CONSTS_VH
`define CMPS_CONSTS_VH

// clocking mode codes held after reset
`define CMPS_MODE_DIV2 2'h0
`define CMPS_MODE_X1 2'h1
`define CMPS_MODE_X4 2'h2

// strap field positions in the sampled select pair
`define CMPS_SEL1_BIT 0
`define CMPS_SEL2_BIT 1

// select pair levels; both high (pulled up) is the default times-four mode
`define CMPS_SEL_DIV2 2'h0
`define CMPS_SEL_X1 2'h1

// pll settling time in microseconds, and clock period in nanoseconds
`define CMPS_PLL_LOCK_US 1000
`define CMPS_CLK_PERIOD_NS 10

// least cycles of the pll settle time, rounded up
`define CMPS_PLL_LOCK_CYC ((`CMPS_PLL_LOCK_US * 1000 + `CMPS_CLK_PERIOD_NS - 1) / `CMPS_CLK_PERIOD_NS)

`endif

// [rtl/cmps_sync2.v]
`timescale 1ns/10ps

// two-flop synchroniser for asynchronous strap pins
module cmps_sync2 #(
    parameter WIDTH = 2
) (
    clk,
    rst_b,
    d,
    q
);
    input wire clk;
    input wire rst_b;
    input wire [WIDTH-1:0] d;
    output reg [WIDTH-1:0] q;

    reg [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {WIDTH{1'b1}};
            q <= {WIDTH{1'b1}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // cmps_sync2

// [rtl/cmps_clock_mode.v]
`timescale 1ns/10ps
`include "cmps_consts.vh"

// Behaviour
// - divide-by-two: pll off, half input rate
// - times-one: pll on, same rate
// - times-four: pll on, four times rate
// - times-four is default; required above 40 mhz
// - mode chosen from select pins during reset
// - two clock outputs, rate choice, drive enables
module cmps_clock_mode #(
    parameter LOCK_CYCLES = `CMPS_PLL_LOCK_CYC
) (
    clk,
    rst_b,
    clock_select_1,
    clock_select_2,
    crystal_input,
    powersave_tick,
    out_a_slow,
    out_b_slow,
    out_a_drive,
    out_b_drive,
    mode,
    pll_enable,
    pll_locked,
    sys_clk_en,
    system_clock_out_a,
    system_clock_out_a_oe_b,
    secondary_clock_out,
    secondary_clock_out_oe_b
);
    input wire clk;
    input wire rst_b;
    input wire clock_select_1;
    input wire clock_select_2;
    input wire crystal_input;
    input wire powersave_tick;
    input wire out_a_slow;
    input wire out_b_slow;
    input wire out_a_drive;
    input wire out_b_drive;
    output reg [1:0] mode;
    output reg pll_enable;
    output reg pll_locked;
    output reg sys_clk_en;
    output reg system_clock_out_a;
    output reg system_clock_out_a_oe_b;
    output reg secondary_clock_out;
    output reg secondary_clock_out_oe_b;

    // this model runs on a fast sampling clock; crystal_input is a slower pin whose
    // edges we count, and sys_clk_en pulses once per generated system clock edge;
    // the pll ratio is only emulated here: rates are counted, not phase-aligned,
    // so the output pins must not be treated as low-jitter clocks

    // synchronised pin levels
    wire [1:0] sel_s;
    wire xin_s;
    // input edge detect and capture flag
    reg xin_d_r;
    reg strap_taken_r;
    // tick divider and settle count
    reg [1:0] div_cnt_r;
    reg [31:0] lock_cnt_r;
    // waveforms before the pin multiplexers
    reg fund_r;
    reg slow_r;

    // terminal count of the settle counter, sized to the counter so the
    // compare needs no extension
    localparam [31:0] LOCK_LAST = LOCK_CYCLES - 1;

    // straps are asynchronous pins; sync before use. this pair is never cleared:
    // it must go on tracking the pins while reset is held, otherwise the first
    // edge after release would latch the flops' reset value instead of the straps
    cmps_sync2 #(.WIDTH(2)) u_sel_sync (
        .clk(clk),
        .rst_b(1'b1),
        .d({clock_select_2, clock_select_1}),
        .q(sel_s)
    );

    // the input clock is only seen as a level, so it is synchronised as well;
    // two flops of delay shift every system edge but do not change the rate;
    // it restarts from the high reset level, which the edge detector matches
    cmps_sync2 #(.WIDTH(1)) u_xin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(crystal_input),
        .q(xin_s)
    );

    // strap decode, shared by the mode latch and the pll enable;
    // any pair other than the two explicit ones falls to the default mode
    function [1:0] decode_mode;
        input [1:0] sel;
        begin
            case (sel)
                `CMPS_SEL_DIV2: decode_mode = `CMPS_MODE_DIV2;
                `CMPS_SEL_X1: decode_mode = `CMPS_MODE_X1;
                default: decode_mode = `CMPS_MODE_X4;
            endcase
        end
    endfunction

    // one-cycle rise of the synchronised input clock
    wire xin_rise = xin_s & ~xin_d_r;

    // strap capture on the first edge after release, then frozen until next reset;
    // the reset value is the default mode so outputs are defined meanwhile;
    // straps that change later have no effect and raise no flag
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= `CMPS_MODE_X4;
            strap_taken_r <= 1'b0;
            pll_enable <= 1'b0;
        end else if (!strap_taken_r) begin
            mode <= decode_mode(sel_s);
            pll_enable <= (decode_mode(sel_s) != `CMPS_MODE_DIV2);
            strap_taken_r <= 1'b1;
        end
    end

    // pll settle counter; generated clock is withheld until lock (1 ms)
    // the count runs in sampling clocks; a short LOCK_CYCLES only suits simulation
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_cnt_r <= 32'h0000_0000;
            pll_locked <= 1'b0;
        end else if (strap_taken_r && !pll_locked) begin
            // divide-by-two runs without the pll, so it is ready at once
            if (!pll_enable) begin
                pll_locked <= 1'b1; // no pll, no settle wait
            end else if (lock_cnt_r >= LOCK_LAST) begin
                pll_locked <= 1'b1;
            end else begin
                lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
            end
        end
    end

    // system clock edge generation from input rising edges.
    // times-four emits four ticks per input edge, which needs clk >= 8x input;
    // a real pll multiplies in analog, this is a cycle-count stand-in;
    // a faster input would merge bursts and lose system edges
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xin_d_r <= 1'b1; // same as the sync reset level, so no false rise
            div_cnt_r <= 2'h0;
            sys_clk_en <= 1'b0;
        end else begin
            xin_d_r <= xin_s;
            sys_clk_en <= 1'b0;
            if (pll_locked) begin
                case (mode)
                    // pll off: one system edge per two input rises
                    `CMPS_MODE_DIV2: begin
                        if (xin_rise) begin
                            div_cnt_r <= div_cnt_r ^ 2'h1;
                            sys_clk_en <= div_cnt_r[0];
                        end
                    end
                    // pll on: a system edge follows each input rise
                    `CMPS_MODE_X1: begin
                        sys_clk_en <= xin_rise;
                    end
                    // pll on: a burst of four edges per input rise
                    `CMPS_MODE_X4: begin
                        if (xin_rise) begin
                            div_cnt_r <= 2'h3;
                            sys_clk_en <= 1'b1;
                        end else if (div_cnt_r != 2'h0) begin
                            div_cnt_r <= div_cnt_r - 2'h1;
                            sys_clk_en <= 1'b1;
                        end
                    end
                    // the unused code gives no edges
                    default: sys_clk_en <= 1'b0;
                endcase
            end
        end
    end

    // fundamental and power-save waveforms toggle on their ticks;
    // the power-save rate is the fundamental gated by a tick made outside
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fund_r <= 1'b0;
            slow_r <= 1'b0;
        end else begin
            if (sys_clk_en) begin
                fund_r <= ~fund_r;
            end
            if (sys_clk_en && powersave_tick) begin
                slow_r <= ~slow_r;
            end
        end
    end

    // output pins: rate select and active-low drive enables per pin;
    // a disabled pin keeps following its waveform, only its enable goes high;
    // enables are registered, so they settle one edge after the request
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            system_clock_out_a <= 1'b0;
            secondary_clock_out <= 1'b0;
            system_clock_out_a_oe_b <= 1'b1;
            secondary_clock_out_oe_b <= 1'b1;
        end else begin
            system_clock_out_a <= out_a_slow ? slow_r : fund_r;
            secondary_clock_out <= out_b_slow ? slow_r : fund_r;
            system_clock_out_a_oe_b <= ~out_a_drive;
            secondary_clock_out_oe_b <= ~out_b_drive;
        end
    end
endmodule // cmps_clock_mode

// [tb/cmps_clock_mode_checker.sv]
`timescale 1ns/10ps
// watches the mode latch, the pll settle count and the pin enables
module cmps_clock_mode_checker #(
    parameter LOCK_CYCLES = 100000
) (
    input wire clk,
    input wire rst_b,
    input wire [1:0] mode,
    input wire pll_enable,
    input wire pll_locked,
    input wire sys_clk_en,
    input wire out_a_drive,
    input wire out_b_drive,
    input wire system_clock_out_a_oe_b,
    input wire secondary_clock_out_oe_b
);
    int cnt_r;
    // edges since release; saturates so the late-lock check fires once
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            cnt_r <= 0;
        else if (cnt_r < LOCK_CYCLES + 8)
            cnt_r <= cnt_r + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // times-four: four system edges back to back, then a gap
    sequence burst4_s;
        sys_clk_en [*4] ##1 !sys_clk_en;
    endsequence
    mode_code_a: assert property (mode != 2'h3)
        else $error("mode code out of range");
    pll_state_a: assert property ($past(rst_b) |-> pll_enable == (mode != 2'h0))
        else $error("pll enable disagrees with mode");
    mode_frozen_a: assert property ($past(rst_b, 2) |-> $stable(mode))
        else $error("mode changed after capture");
    lock_early_a: assert property (pll_locked && mode != 2'h0 |-> cnt_r >= LOCK_CYCLES)
        else $error("pll locked before settle time");
    lock_late_a: assert property (cnt_r == LOCK_CYCLES + 4 |-> pll_locked)
        else $error("pll never locked");
    gated_edge_a: assert property (!pll_locked |-> !sys_clk_en)
        else $error("system edge before lock");
    x4_burst_a: assert property ($rose(sys_clk_en) && $past(pll_locked, 2) && mode == 2'h2 |-> burst4_s)
        else $error("times-four burst not four edges");
    single_edge_a: assert property ($rose(sys_clk_en) && mode != 2'h2 |=> !sys_clk_en)
        else $error("more than one edge per input rise");
    drive_a_oe_a: assert property ($past(rst_b) |-> system_clock_out_a_oe_b == !$past(out_a_drive))
        else $error("pin a enable wrong");
    drive_b_oe_a: assert property ($past(rst_b) |-> secondary_clock_out_oe_b == !$past(out_b_drive))
        else $error("pin b enable wrong");
endmodule // cmps_clock_mode_checker

bind cmps_clock_mode cmps_clock_mode_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.clk, .rst_b,
    .mode, .pll_enable, .pll_locked, .sys_clk_en, .out_a_drive, .out_b_drive,
    .system_clock_out_a_oe_b, .secondary_clock_out_oe_b);

// [tb/cmps_xtal_model.sv]
`timescale 1ns/10ps
// free-running source on the crystal pin; an oscillator never stops
module cmps_xtal_model #(
    parameter HALF_NS = 60
) (
    output logic crystal_input
);
    // 120 ns period keeps the input below an eighth of the sampling clock
    initial begin
        crystal_input = 1'b0;
        forever #(HALF_NS) crystal_input = ~crystal_input;
    end
endmodule // cmps_xtal_model

// [tb/cmps_clock_mode_tb_top.sv]
`timescale 1ns/10ps
module cmps_clock_mode_tb_top;
    logic clk, rst_b, clock_select_1, clock_select_2, powersave_tick, last_a, last_b;
    logic out_a_slow, out_b_slow, out_a_drive, out_b_drive;
    wire crystal_input, pll_enable, pll_locked, sys_clk_en, system_clock_out_a;
    wire system_clock_out_a_oe_b, secondary_clock_out, secondary_clock_out_oe_b;
    wire [1:0] mode;
    int errors, compares, pulses, edges_a, edges_b;
    cmps_xtal_model xtal_u (.crystal_input);
    cmps_clock_mode #(.LOCK_CYCLES(20)) dut_u (.clk, .rst_b, .clock_select_1, .clock_select_2,
        .crystal_input, .powersave_tick, .out_a_slow, .out_b_slow, .out_a_drive, .out_b_drive,
        .mode, .pll_enable, .pll_locked, .sys_clk_en, .system_clock_out_a,
        .system_clock_out_a_oe_b, .secondary_clock_out, .secondary_clock_out_oe_b);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counted on the falling edge, where outputs have settled
    always @(negedge clk) begin
        pulses += (sys_clk_en === 1'b1);
        edges_a += (system_clock_out_a !== last_a);
        edges_b += (secondary_clock_out !== last_b);
        last_a = system_clock_out_a;
        last_b = secondary_clock_out;
    end
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic near(input int a, input int b);
        return (a - b <= 4) && (b - a <= 4);
    endfunction
    // straps set inside reset, well over the two edges the sync flops need
    task automatic boot(input logic [1:0] sel);
        @(posedge clk);
        #1 {clock_select_2, clock_select_1} = sel;
        rst_b = 1'b0;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (40) @(posedge clk); // settle count plus margin
        #1;
    endtask
    // ratio is system edges per two input rises; window spans 16 rises
    task automatic run_mode(input logic [1:0] sel, input logic [1:0] m, input int ratio);
        boot(sel);
        check(mode, m);
        check({1'b0, pll_enable}, {1'b0, m != 2'h0});
        check({1'b0, pll_locked}, 2'h1);
        {clock_select_2, clock_select_1} = ~sel;
        @(posedge crystal_input);
        pulses = 0;
        edges_a = 0;
        edges_b = 0;
        repeat (16) @(posedge crystal_input);
        check({1'b0, near(pulses * 2, ratio * 16)}, 2'h1);
        check({1'b0, near(edges_a, pulses)}, 2'h1);
        check({1'b0, edges_b == 0}, 2'h1); // power-save clock held by its gate
        check(mode, m);
    endtask
    task automatic scen_x4_default;
        run_mode(2'h3, 2'h2, 8);
    endtask
    task automatic scen_x4_alt;
        run_mode(2'h2, 2'h2, 8);
    endtask
    task automatic scen_div2;
        run_mode(2'h0, 2'h0, 1); // slow target rate picks divide-by-two
    endtask
    task automatic scen_x1;
        run_mode(2'h1, 2'h1, 2);
    endtask
    // swapped rate selects; tick low then high: the slow pin stands, then moves
    task automatic scen_powersave;
        for (int t = 0; t < 2; t++) begin
            @(posedge clk);
            #1 {out_a_slow, out_b_slow, powersave_tick} = {2'h2, t[0]};
            repeat (2) @(posedge crystal_input);
            pulses = 0;
            edges_a = 0;
            edges_b = 0;
            repeat (8) @(posedge crystal_input);
            check({1'b0, near(pulses, 8)}, 2'h1);
            check({1'b0, near(edges_a, t * pulses)}, 2'h1);
            check({1'b0, near(edges_b, pulses)}, 2'h1);
        end
    endtask
    // each pin enable alone, so a swapped pair shows
    task automatic scen_drive;
        for (int i = 1; i < 3; i++) begin
            @(posedge clk);
            #1 {out_a_drive, out_b_drive} = i[1:0];
            repeat (2) @(posedge clk);
            #1 check({system_clock_out_a_oe_b, secondary_clock_out_oe_b}, ~i[1:0]);
        end
    endtask
    initial begin
        {rst_b, clock_select_2, clock_select_1, powersave_tick} = 4'h6;
        {out_a_slow, out_b_slow, out_a_drive, out_b_drive} = 4'h7;
        scen_x4_default;
        scen_x4_alt;
        scen_div2;
        scen_x1;
        scen_powersave;
        scen_drive;
        tally_and_finish;
    end
    // whole run needs about 12 us; a hang is cut at 100 us
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
endmodule // cmps_clock_mode_tb_top
